// file: rtl/clkgen_pkg.sv
/*
 * Shared constants and types for the ISA and suspend clock generator.
 * Assumes a 200 MHz system clock; every external clock arrives
 * asynchronously as a plain pin and is oversampled.
 */
package clkgen_pkg;

   // System clock period in picoseconds (200 MHz)
   localparam int unsigned SYS_PERIOD_PS = 5000;

   // ISA clock is the PCI clock divided by this ratio
   localparam int unsigned ISA_DIV       = 4;
   // Phase at which the divided clock goes high
   localparam logic [1:0]  ISA_HIGH_PH   = 2'h2;
   // Last low phase; stretching holds the divider here
   localparam logic [1:0]  ISA_LAST_LO   = 2'h1;
   // Last phase of an ISA period
   localparam logic [1:0]  ISA_LAST_PH   = 2'h3;

   // Longest ISA period still counted as the 8.33 MHz rate, in ns
   // (8.33 MHz gives 120 ns, 7.5 MHz gives 133 ns)
   localparam int unsigned ISA_FAST_MAX_NS = 127;
   localparam int unsigned ISA_FAST_MAX_CY =
      (ISA_FAST_MAX_NS * 1000) / SYS_PERIOD_PS;
   localparam logic [7:0]  ISA_FAST_MAX  = 8'(ISA_FAST_MAX_CY);

   // Silence after which a clock input is reported as stopped, in ns
   localparam int unsigned PCI_STOP_NS   = 100;
   localparam int unsigned USB_STOP_NS   = 100;
   localparam int unsigned OSC_STOP_NS   = 300;
   localparam int unsigned PCI_STOP_CY   =
      (PCI_STOP_NS * 1000) / SYS_PERIOD_PS;
   localparam int unsigned USB_STOP_CY   =
      (USB_STOP_NS * 1000) / SYS_PERIOD_PS;
   localparam int unsigned OSC_STOP_CY   =
      (OSC_STOP_NS * 1000) / SYS_PERIOD_PS;

   // System power states as seen by the clock generator
   typedef enum logic [2:0] {
      SUS_ON   = 3'h0,
      SUS_POS  = 3'h1,
      SUS_STR  = 3'h2,
      SUS_STD  = 3'h3,
      SUS_SOFF = 3'h4
   } susp_state_t;

endpackage : clkgen_pkg

// file: rtl/clk_probe_if.sv
/*
 * Carrier between the clock generator and its clock activity monitors.
 * Assumes all three signals live in the system clock domain except raw,
 * which is the untouched pin level.
 */
`timescale 1ns/1ps
interface clk_probe_if;
   logic raw;        // Pin level, asynchronous
   logic rise;       // One-cycle pulse on a synchronised rising edge
   logic running;    // Level: edges seen recently

   modport mon  (input raw, output rise, output running);
   modport user (output raw, input rise, input running);
endinterface : clk_probe_if

// file: rtl/clk_activity_mon.sv
/*
 * Clock activity monitor: synchronises a foreign clock pin, gives a pulse
 * on each rising edge and flags whether the clock is still toggling.
 * Assumes a stopped clock is legal and must not hang anything downstream.
 */
`timescale 1ns/1ps
module clk_activity_mon
   import clkgen_pkg::*;
#(
   parameter int unsigned TIMEOUT = 20   // Idle cycles before "stopped"
)(
   // Clock and reset
   input wire logic  CLK_SYS,
   input wire logic  RST_N,
   // Probe toward the user
   clk_probe_if.mon  PRB
);

   localparam int unsigned CW  = $clog2(TIMEOUT + 1);
   localparam logic [CW-1:0] LIM = CW'(TIMEOUT);

   // Elaboration check: a timeout below two leaves no idle window
   if (TIMEOUT < 2) begin : g_bad_timeout
      $error("clk_activity_mon: TIMEOUT must be at least 2");
   end

   logic          s1_r;        // First synchroniser stage
   logic          s2_r;        // Second stage, first usable level
   logic          s3_r;        // Delayed copy for edge detect
   logic [CW-1:0] idle_cnt_r;  // Cycles since last rising edge
   logic          running_r;   // Activity flag

   // Two-flop synchroniser plus one stage for edge detection. The stages
   // reset high, so a pin already high at release shows no false rise
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
      end else begin
         s1_r <= PRB.raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Only the second stage and its copy feed the edge detector
   assign PRB.rise = s2_r & ~s3_r;

   // Idle counter saturates, so a stopped clock costs nothing
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         idle_cnt_r <= '0;
      end else if (PRB.rise) begin
         idle_cnt_r <= '0;
      end else if (idle_cnt_r != LIM) begin
         idle_cnt_r <= idle_cnt_r + 1'b1;
      end
   end

   // Running drops after a full timeout of silence
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         running_r <= 1'b0;
      end else begin
         running_r <= PRB.rise | (idle_cnt_r != LIM);
      end
   end

   assign PRB.running = running_r;

   AST_IDLE_STOPS: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      (idle_cnt_r == LIM) && !PRB.rise |=> !running_r)
      else $error("Monitor kept running after timeout");

   AST_EDGE_RUNS: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      PRB.rise |=> running_r && (idle_cnt_r == '0))
      else $error("Monitor missed a clock edge");

endmodule : clk_activity_mon

// file: rtl/isa_and_suspend_clock_gen.sv
/*
 * ISA bus clock and suspend refresh clock generator. The ISA clock is the
 * PCI clock divided by four, stretched low on request and parked low in
 * power-on suspend. The refresh clock follows the RTC crystal and stops in
 * suspend-to-disk and soft-off. USB and timer clock activity is reported.
 * Assumes every clock pin is asynchronous to CLK_SYS and that CLK_SYS is
 * at least six times faster than the PCI clock.
 */
`timescale 1ns/1ps

// Function
// - ISA clock is PCI clock divided by four
// - ISA clock runs 7.5 or 8.33 MHz
// - PCI-to-ISA access may stretch clock low
// - Runs in and after reset, low in POS; here held low while RST_N is low
// - Refresh clock out, stopped in disk/soft-off
// - PCI timing referenced to PCI rising edge
// - USB 48 MHz clock may stop
// - Timer oscillator clock may stop
module isa_and_suspend_clock_gen
   import clkgen_pkg::*;
(
   // System clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        RST_N,
   // External clock pins
   input  wire logic        PCI_BUS_CLOCK_IN,
   input  wire logic        USB_48M_CLOCK_IN,
   input  wire logic        TIMER_OSC_CLOCK_IN,
   input  wire logic        RTC_CRYSTAL_IN,
   // Power state and bridge control, same clock domain
   input  susp_state_t      SUSP_STATE,
   input  wire logic        ISA_STRETCH_REQ,
   // Generated clocks
   output logic             ISA_BUS_CLOCK,
   output logic             SUSPEND_REFRESH_CLOCK,
   // Status
   output logic             ISA_RATE_FAST,
   output logic             PCI_CLK_RUNNING,
   output logic             USB_CLK_RUNNING,
   output logic             TIMER_CLK_RUNNING
);

   clk_probe_if pci_prb ();   // PCI clock probe
   clk_probe_if usb_prb ();   // USB clock probe
   clk_probe_if osc_prb ();   // Timer oscillator probe

   logic [1:0] phase_r;       // Divider phase, counts PCI rising edges
   logic [1:0] phase_nxt;     // Next divider phase
   logic [7:0] per_cnt_r;     // System cycles in the current ISA period
   logic       stretched_r;   // Current ISA period was stretched
   logic       rate_fast_r;   // Last clean period was the 8.33 MHz one
   logic       isa_clk_r;     // ISA clock flop
   logic       rtc_s1_r;      // RTC synchroniser, first stage
   logic       rtc_s2_r;      // RTC synchroniser, second stage
   logic       sus_clk_r;     // Refresh clock flop
   logic       hold_lo;       // Divider held in its last low phase
   logic       wrap;          // ISA period ends on this cycle

   // Pins into the probes
   assign pci_prb.raw = PCI_BUS_CLOCK_IN;
   assign usb_prb.raw = USB_48M_CLOCK_IN;
   assign osc_prb.raw = TIMER_OSC_CLOCK_IN;

   // PCI clock probe; its edges drive the divider
   clk_activity_mon #(.TIMEOUT(PCI_STOP_CY)) u_pci_mon (
      .CLK_SYS (CLK_SYS),
      .RST_N   (RST_N),
      .PRB     (pci_prb.mon)
   );

   // USB clock probe; only reports, never blocks
   clk_activity_mon #(.TIMEOUT(USB_STOP_CY)) u_usb_mon (
      .CLK_SYS (CLK_SYS),
      .RST_N   (RST_N),
      .PRB     (usb_prb.mon)
   );

   // Timer oscillator probe; only reports, never blocks
   clk_activity_mon #(.TIMEOUT(OSC_STOP_CY)) u_osc_mon (
      .CLK_SYS (CLK_SYS),
      .RST_N   (RST_N),
      .PRB     (osc_prb.mon)
   );

   // Stretch only at the low-to-high boundary, so the rising edge
   // lands on a PCI edge chosen by the bridge
   assign hold_lo = ISA_STRETCH_REQ && (phase_r == ISA_LAST_LO);
   assign wrap    = pci_prb.rise && (phase_r == ISA_LAST_PH);

   // Next phase: advances only on a PCI rising edge
   always_comb begin
      phase_nxt = phase_r;
      if (pci_prb.rise && !hold_lo) begin
         phase_nxt = phase_r + 2'h1;   // Modulo four divide
      end
   end

   // Divider phase. Bus reset elsewhere does not touch it, so the clock
   // keeps running through a bus reset; only RST_N parks it
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         phase_r <= 2'h0;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   // ISA clock: high half of the divide, forced low in POS
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         isa_clk_r <= 1'b0;
      end else if (SUSP_STATE == SUS_POS) begin
         isa_clk_r <= 1'b0;
      end else begin
         isa_clk_r <= (phase_r >= ISA_HIGH_PH);
      end
   end

   assign ISA_BUS_CLOCK = isa_clk_r;

   // Period measurement; a stretched period says nothing about the rate,
   // so it is skipped rather than misread as the slow rate
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         per_cnt_r   <= 8'h00;
         stretched_r <= 1'b0;
      end else if (wrap) begin
         per_cnt_r   <= 8'h00;
         stretched_r <= 1'b0;
      end else begin
         if (per_cnt_r != 8'hFF) begin
            per_cnt_r <= per_cnt_r + 8'h01;
         end
         if (pci_prb.rise && hold_lo) begin
            stretched_r <= 1'b1;
         end
      end
   end

   // Rate flag: 8.33 MHz when the period fits, else 7.5 MHz. The count
   // at wrap is one less than the period in cycles, hence the strict
   // compare; a 26-cycle slow period must not pass as fast
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         rate_fast_r <= 1'b0;
      end else if (wrap && !stretched_r) begin
         rate_fast_r <= (per_cnt_r < ISA_FAST_MAX);
      end
   end

   assign ISA_RATE_FAST = rate_fast_r;

   // RTC crystal synchroniser
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         rtc_s1_r <= 1'b0;
         rtc_s2_r <= 1'b0;
      end else begin
         rtc_s1_r <= RTC_CRYSTAL_IN;
         rtc_s2_r <= rtc_s1_r;
      end
   end

   // Refresh clock follows the crystal except in disk and soft-off.
   // Jitter of one system cycle is harmless at 32.768 kHz
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         sus_clk_r <= 1'b0;
      end else if (SUSP_STATE == SUS_STD || SUSP_STATE == SUS_SOFF) begin
         sus_clk_r <= 1'b0;
      end else begin
         sus_clk_r <= rtc_s2_r;
      end
   end

   assign SUSPEND_REFRESH_CLOCK = sus_clk_r;

   // Activity status; a missing PCI clock freezes the ISA clock
   assign PCI_CLK_RUNNING   = pci_prb.running;
   assign USB_CLK_RUNNING   = usb_prb.running;
   assign TIMER_CLK_RUNNING = osc_prb.running;

   AST_DIV_STEP: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      pci_prb.rise && !ISA_STRETCH_REQ |=>
         phase_r == $past(phase_r) + 2'h1)
      else $error("Divider did not advance on PCI edge");

   AST_PCI_EDGE_ONLY: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      !pci_prb.rise |=> phase_r == $past(phase_r))
      else $error("Divider moved without a PCI rising edge");

   AST_STRETCH_HOLD: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      ISA_STRETCH_REQ && phase_r == ISA_LAST_LO |=>
         phase_r == ISA_LAST_LO ##1 !ISA_BUS_CLOCK)
      else $error("Stretch did not hold the ISA clock low");

   AST_STRETCH_WHOLE: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      $changed(phase_r) |-> $past(pci_prb.rise))
      else $error("ISA phase changed off a PCI period boundary");

   AST_POS_LOW: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      SUSP_STATE == SUS_POS |=> !ISA_BUS_CLOCK)
      else $error("ISA clock not low in power-on suspend");

   AST_ISA_RUNS: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      SUSP_STATE != SUS_POS && phase_r >= ISA_HIGH_PH |=>
         ISA_BUS_CLOCK)
      else $error("ISA clock low in its high half");

   AST_RATE: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      wrap && !stretched_r |=>
         ISA_RATE_FAST == ($past(per_cnt_r) < ISA_FAST_MAX))
      else $error("ISA rate flag wrong");

   AST_SUS_STOP: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      SUSP_STATE == SUS_STD || SUSP_STATE == SUS_SOFF |=>
         !SUSPEND_REFRESH_CLOCK)
      else $error("Refresh clock running in disk or soft-off");

   AST_SUS_FOLLOW: assert property (
      @(posedge CLK_SYS) disable iff (!RST_N)
      SUSP_STATE == SUS_STR |=> SUSPEND_REFRESH_CLOCK == $past(rtc_s2_r))
      else $error("Refresh clock stopped in suspend-to-RAM");

endmodule : isa_and_suspend_clock_gen

// file: tb/clk_sources.sv
/*
 * Model of the clock pins feeding the clock generator: PCI, USB,
 * timer oscillator and RTC crystal.
 * Assumes the bench drives the run controls from time zero.
 */
`timescale 1ns/1ps
module clk_sources (
   // Run controls from the bench
   input  wire logic pci_run,
   input  wire logic pci_fast,
   input  wire logic usb_run,
   input  wire logic osc_run,
   // Clock pins
   output logic      pci_clk,
   output logic      usb_clk,
   output logic      osc_clk,
   output logic      rtc_clk
);
   // PCI clock, 33 or 30 MHz; it stops only when the bench asks
   always begin
      if (pci_run === 1'b1) begin
         #(pci_fast ? 15.0 : 16.667);
         pci_clk = (pci_clk !== 1'b1);
      end else begin
         pci_clk = 1'b0;   // A stopped clock stands still low
         @(pci_run);
      end
   end

   // USB 48 MHz clock, may stop in suspend
   always begin
      if (usb_run === 1'b1) begin
         #10.417 usb_clk = (usb_clk !== 1'b1);
      end else begin
         usb_clk = 1'b0;
         @(usb_run);
      end
   end

   // Timer oscillator 14.31818 MHz, may stop in suspend
   always begin
      if (osc_run === 1'b1) begin
         #34.92 osc_clk = (osc_clk !== 1'b1);
      end else begin
         osc_clk = 1'b0;
         @(osc_run);
      end
   end

   // RTC crystal 32.768 kHz never stops; starts low so no unknown
   // level reaches the refresh clock path
   initial begin
      rtc_clk = 1'b0;
      forever #15258.789 rtc_clk = ~rtc_clk;
   end
endmodule : clk_sources

// file: tb/tb_isa_and_suspend_clock_gen.sv
/*
 * Self-checking bench for the ISA and suspend clock generator.
 * Assumes clk_sources models every clock pin and a 200 MHz CLK_SYS.
 */
`timescale 1ns/1ps
module tb_isa_and_suspend_clock_gen
   import clkgen_pkg::*;
;
   logic        clk       = 1'b0;     // System clock
   logic        rst_n     = 1'b0;     // Synchronous reset
   susp_state_t susp      = SUS_ON;   // Power state
   logic        stretch   = 1'b0;     // Stretch request
   logic        pci_run   = 1'b1;     // Source controls
   logic        pci_fast  = 1'b1;
   logic        usb_run   = 1'b1;
   logic        osc_run   = 1'b1;
   logic        pci_clk, usb_clk, osc_clk, rtc_clk;
   logic        isa, refr, rate_fast, pci_ok, usb_ok, osc_ok;
   int          num_errors = 0;
   int          n_compared = 0;
   int          cycles     = 0;        // Watchdog count

   clk_sources i_clk_sources (.pci_run(pci_run), .pci_fast(pci_fast),
      .usb_run(usb_run), .osc_run(osc_run), .pci_clk(pci_clk),
      .usb_clk(usb_clk), .osc_clk(osc_clk), .rtc_clk(rtc_clk));

   isa_and_suspend_clock_gen i_isa_and_suspend_clock_gen (
      .CLK_SYS(clk), .RST_N(rst_n), .PCI_BUS_CLOCK_IN(pci_clk),
      .USB_48M_CLOCK_IN(usb_clk), .TIMER_OSC_CLOCK_IN(osc_clk),
      .RTC_CRYSTAL_IN(rtc_clk), .SUSP_STATE(susp),
      .ISA_STRETCH_REQ(stretch), .ISA_BUS_CLOCK(isa),
      .SUSPEND_REFRESH_CLOCK(refr), .ISA_RATE_FAST(rate_fast),
      .PCI_CLK_RUNNING(pci_ok), .USB_CLK_RUNNING(usb_ok),
      .TIMER_CLK_RUNNING(osc_ok));

   // 200 MHz system clock
   initial begin
      forever #2.5 clk = ~clk;
   end

   // Watchdog; sized well above the longest expected run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         report_and_stop();
      end
   end

   // Inputs move 1 ns after an edge so sampling never races
   task automatic step(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task automatic check_bit(logic got, logic exp, string what);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t: %s got %b exp %b", $time, what, got, exp);
      end
   endtask : check_bit

   // Sync jitter of one system cycle per edge is allowed for by tol
   task automatic check_near(real got, real exp, real tol, string what);
      n_compared++;
      if (got < exp - tol || got > exp + tol) begin
         num_errors++;
         $display("[FAIL] %0t: %s got %f exp %f", $time, what, got, exp);
      end
   endtask : check_near

   // One full ISA period from rising edge to rising edge
   task automatic isa_period(output real per, output real hi);
      real t0;
      @(posedge isa);
      t0 = $realtime;
      @(negedge isa);
      hi = $realtime - t0;
      @(posedge isa);
      per = $realtime - t0;
   endtask : isa_period

   task automatic t_divide(logic fast);
      real per, hi, tp;
      tp = fast ? 30.0 : 33.334;
      pci_fast = fast;
      repeat (3) isa_period(per, hi);   // Let the new rate settle
      isa_period(per, hi);
      check_near(per, 4.0 * tp, 6.0, "isa period");
      check_near(hi, 2.0 * tp, 6.0, "isa high");
      step(2);
      check_bit(rate_fast, fast, "rate flag");
   endtask : t_divide

   // Hold the request for 300 ns inside a low phase
   task automatic t_stretch();
      real t0, lo, per, hi;
      int  n;
      @(negedge isa);
      t0 = $realtime;
      step(1);
      stretch = 1'b1;
      step(60);
      stretch = 1'b0;
      @(posedge isa);
      lo = $realtime - t0;
      n  = $rtoi(lo / 30.0 + 0.5);
      check_bit(n > 3, 1'b1, "stretched low");
      check_near(lo, n * 30.0, 6.0, "whole periods");
      isa_period(per, hi);
      check_near(per, 120.0, 6.0, "period after stretch");
   endtask : t_stretch

   task automatic t_refresh();
      real t0;
      @(posedge refr);
      t0 = $realtime;
      @(posedge refr);
      check_near($realtime - t0, 30517.578, 6.0, "refresh period");
   endtask : t_refresh

   // Each window outlasts one refresh period, so a live clock shows a rise
   task automatic t_states();
      susp_state_t st[4]      = '{SUS_POS, SUS_STR, SUS_STD, SUS_SOFF};
      logic        isa_exp[4] = '{1'b0, 1'b1, 1'b1, 1'b1};
      logic        ref_exp[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
      int          ni, nr;
      logic        pi, pr;
      for (int i = 0; i < 4; i++) begin
         susp = st[i];
         step(2);
         ni = 0;
         nr = 0;
         pi = isa;
         pr = refr;
         repeat (6400) begin
            step(1);
            if (isa && !pi) ni++;
            if (refr && !pr) nr++;
            pi = isa;
            pr = refr;
         end
         check_bit(ni > 0, isa_exp[i], "isa toggles");
         check_bit(nr > 0, ref_exp[i], "refresh toggles");
         if (!isa_exp[i]) check_bit(isa, 1'b0, "isa parked");
         if (!ref_exp[i]) check_bit(refr, 1'b0, "refresh parked");
      end
      susp = SUS_ON;
      step(2);
   endtask : t_states

   // Stop and restart PCI, USB and timer clocks in turn
   task automatic t_monitors();
      logic ok;
      for (int i = 0; i < 3; i++) begin
         for (int v = 0; v < 2; v++) begin
            case (i)
               0: pci_run = v[0];
               1: usb_run = v[0];
               default: osc_run = v[0];
            endcase
            step(100);
            ok = (i == 0) ? pci_ok : (i == 1) ? usb_ok : osc_ok;
            check_bit(ok, v[0], "clock running flag");
         end
      end
   endtask : t_monitors

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   // Main sequence
   initial begin
      step(5);
      check_bit(isa, 1'b0, "isa in reset");
      check_bit(refr, 1'b0, "refresh in reset");
      rst_n = 1'b1;
      step(40);
      t_divide(1'b0);
      t_divide(1'b1);
      t_stretch();
      t_refresh();
      t_states();
      t_monitors();
      report_and_stop();
   end
endmodule : tb_isa_and_suspend_clock_gen
